// >>> bench/testbench.sv
// Register-level bench for the three-channel timer
`timescale 1ns/100ps
module testbench;
  logic mclk, resetn, rd, wr, wreq;
  logic [7:0] adr;
  logic [31:0] wd, rdata, got;
  logic [2:0] pc, ai, ao, aoe, bi, bo, boe, bdrv;
  int n_mismatch, samples_checked;
  ttc_top ttc_top_i (.mclk(mclk), .resetn(resetn), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .pin_clock(pc), .io_pin_a_in(ai), .io_pin_a_out(ao),
    .io_pin_a_oe(aoe), .io_pin_b_in(bi), .io_pin_b_out(bo), .io_pin_b_oe(boe));
  ttc_pins_model ttc_pins_model_i (.a_out(ao), .a_oe(aoe), .b_out(bo), .b_oe(boe),
    .b_drive(bdrv), .a_in(ai), .b_in(bi), .pin_clock(pc));
  // Clock at 100 MHz
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Each access starts a cycle later, so a release never meets a new raise
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    @(posedge mclk);
    while (wreq !== 1'b0) @(posedge mclk);
    got = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(got, exp);
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog well past the expected run of under a thousand cycles
  initial
  begin
    #200000;
    n_mismatch++;
    results;
  end
  initial
  begin
    {rd, wr, adr, wd, bdrv, resetn} = '0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    // Reset values, reserved and channel-strided places
    rchk(8'h44, 32'h0000_0000);
    rchk(8'hC4, 32'h0000_0000);
    rchk(8'h08, 32'h0000_0000);
    rchk(8'h10, 32'h0000_0000);
    bus(1'b1, 8'hC4, 32'h0000_0015);
    rchk(8'hC4, 32'h0000_0015);
    $display("test registers done");
    // value_a locked in capture, open in generation, 16 bits wide
    bus(1'b1, 8'h94, 32'h0000_1234);
    rchk(8'h94, 32'h0000_0000);
    bus(1'b1, 8'h84, 32'h0000_8000);
    bus(1'b1, 8'h94, 32'hFFFF_1234);
    rchk(8'h94, 32'h0000_1234);
    rchk(8'h84, 32'h0000_8000);
    $display("test access done");
    // Pin B direction follows event source
    bus(1'b1, 8'h04, 32'h0040_8000);
    repeat (2) @(posedge mclk);
    chk(boe[0], 1'b0);
    bus(1'b1, 8'h04, 32'h0040_8400);
    repeat (2) @(posedge mclk);
    chk(boe[0], 1'b1);
    chk(aoe[0], 1'b1);
    bus(1'b1, 8'h00, 32'h0000_0004);
    repeat (3) @(posedge mclk);
    chk(ao[0], 1'b1);
    $display("test pins done");
    // Block kick toggles pin A of every channel at once
    bus(1'b1, 8'h04, 32'h00C0_8400);
    bus(1'b1, 8'h44, 32'h00C0_8400);
    bus(1'b1, 8'h84, 32'h00C0_8400);
    bus(1'b1, 8'hC0, 32'h0000_0000);
    repeat (3) @(posedge mclk);
    chk(ao, 3'h1);
    bus(1'b1, 8'hC0, 32'h0000_0001);
    repeat (3) @(posedge mclk);
    chk(ao, 3'h6);
    $display("test kick done");
    // Clock commands and disable on C match
    bus(1'b1, 8'h44, 32'h0000_8080);
    bus(1'b1, 8'h5C, 32'h0000_0100);
    bus(1'b1, 8'h40, 32'h0000_0005);
    rchk(8'h60, 32'h0000_0001);
    repeat (700) @(posedge mclk);
    rchk(8'h60, 32'h0000_0000);
    // Move value_c out of reach so a re-enabled clock is not disabled at once
    bus(1'b1, 8'h5C, 32'h0000_FFFF);
    bus(1'b1, 8'h40, 32'h0000_0001);
    rchk(8'h60, 32'h0000_0001);
    bus(1'b1, 8'h40, 32'h0000_0003);
    rchk(8'h60, 32'h0000_0000);
    bus(1'b1, 8'h40, 32'h0000_0001);
    rchk(8'h60, 32'h0000_0001);
    bus(1'b1, 8'h40, 32'h0000_0002);
    rchk(8'h60, 32'h0000_0000);
    $display("test clock done");
    results;
  end
endmodule

// >>> bench/ttc_pins_model.sv
// Pin-side partner: resolves channel pins and holds the external clock pins still
`timescale 1ns/100ps
module ttc_pins_model
(
  input wire logic [2:0] a_out,
  input wire logic [2:0] a_oe,
  input wire logic [2:0] b_out,
  input wire logic [2:0] b_oe,
  input wire logic [2:0] b_drive,
  output logic [2:0] a_in,
  output logic [2:0] b_in,
  output logic [2:0] pin_clock
);
  // Undriven A pins show the inverse, so a stale value never passes by luck; undriven B pins show b_drive
  assign a_in = (a_oe & a_out) | (~a_oe & ~a_out);
  assign b_in = (b_oe & b_out) | (~b_oe & b_drive);
  // Pin clocks idle low: no frames in these tests
  assign pin_clock = 3'h0;
endmodule

// >>> src/ttc_channel.sv
// One timer channel: clocking, counter, capture loads, compares, output control
`timescale 1ns/100ps
module ttc_channel
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [31:0] mode,
  input wire logic [15:0] va_wr,
  input wire logic va_we,
  input wire logic [15:0] vb_wr,
  input wire logic vb_we,
  input wire logic [15:0] vc,
  input wire logic clk_on,
  input wire logic clk_off,
  input wire logic soft_trig,
  input wire logic [4:0] tick,
  input wire logic [2:0] xc,
  input wire logic pin_a_in,
  input wire logic pin_b_in,
  output logic [15:0] cv,
  output logic [15:0] va,
  output logic [15:0] vb,
  output logic clk_enabled,
  output logic pin_a_out,
  output logic pin_a_oe,
  output logic pin_b_out,
  output logic pin_b_oe
);
  logic gen;
  logic [2:0] pick;
  logic [1:0] gate;
  logic sel_clk;
  logic sel_prev_q;
  logic inc_en;
  logic a_prev_q;
  logic b_prev_q;
  logic ev_prev_q;
  logic tr_prev_q;
  logic run_q;
  logic down_q;
  logic a_done_q;
  logic out_a_q;
  logic out_b_q;
  logic [15:0] cv_q;
  logic [15:0] va_q;
  logic [15:0] vb_q;
  logic ev_sig;
  logic ev_hit;
  logic tr_sig;
  logic ext_trig;
  logic c_hit;
  logic trig;
  logic load_a;
  logic load_b;
  logic pin_b_in_use;
  logic ud_restart;

  // Edge match for a two-bit edge code
  function automatic logic edge_hit(input logic [1:0] code, input logic now, input logic prev);
    edge_hit = ((code == ttc_pkg::EDGE_RISE) && now && !prev)
      || ((code == ttc_pkg::EDGE_FALL) && !now && prev)
      || ((code == ttc_pkg::EDGE_BOTH) && (now != prev));
  endfunction

  // Apply an output action to a pin level
  function automatic logic act(input logic [1:0] code, input logic lvl);
    unique case (code)
      ttc_pkg::ACT_SET: act = 1'b1;
      ttc_pkg::ACT_CLEAR: act = 1'b0;
      ttc_pkg::ACT_TOGGLE: act = !lvl;
      ttc_pkg::ACT_NONE: act = lvl;
    endcase
  endfunction

  assign gen = mode[ttc_pkg::M_GEN];
  assign pick = mode[ttc_pkg::M_CLKPICK_LO +: 3];
  assign gate = mode[ttc_pkg::M_GATE_LO +: 2];

  // Selected clock level, gated by an ext clock on demand
  always_comb
  begin
    unique case (pick)
      3'h5: sel_clk = xc[0];
      3'h6: sel_clk = xc[1];
      3'h7: sel_clk = xc[2];
      default: sel_clk = tick[pick];
    endcase
    if (gate != 2'h0)
      sel_clk = sel_clk & xc[gate - 2'h1];
  end

  // Internal ticks are one-cycle pulses: inverting one would count all but one cycle of each period,
  // so they count as they come; external levels count on the chosen edge
  assign inc_en = !(pick[2] && (pick[1:0] != 2'h0)) ? sel_clk
    : (mode[ttc_pkg::M_INVERT] ? (!sel_clk && sel_prev_q) : (sel_clk && !sel_prev_q));

  // External event / trigger sources
  always_comb
  begin
    unique case (mode[ttc_pkg::M_EVSEL_LO +: 2])
      2'h0: ev_sig = pin_b_in;
      2'h1: ev_sig = xc[0];
      2'h2: ev_sig = xc[1];
      2'h3: ev_sig = xc[2];
    endcase
  end
  assign tr_sig = mode[ttc_pkg::M_TRIGPIN] ? pin_a_in : pin_b_in;
  assign ev_hit = gen && edge_hit(mode[ttc_pkg::M_EVEDGE_LO +: 2], ev_sig, ev_prev_q);
  assign ext_trig = gen ? (ev_hit && mode[ttc_pkg::M_EVTRIG])
    : edge_hit(mode[ttc_pkg::M_TRIGEDGE_LO +: 2], tr_sig, tr_prev_q);
  assign c_hit = (cv_q == vc) && inc_en && run_q;
  assign trig = soft_trig || ext_trig
    || (c_hit && (gen ? mode[ttc_pkg::M_SHAPE_LO + ttc_pkg::SHAPE_RESTART]
                      : mode[ttc_pkg::M_RETRIG_C]));
  assign pin_b_in_use = gen && (mode[ttc_pkg::M_EVSEL_LO +: 2] == ttc_pkg::EVSEL_PIN_B);
  assign ud_restart = gen && mode[ttc_pkg::M_SHAPE_LO + ttc_pkg::SHAPE_UPDOWN]
    && mode[ttc_pkg::M_SHAPE_LO + ttc_pkg::SHAPE_RESTART];

  // Capture loads alternate: value_a first, then value_b
  assign load_a = !gen && !a_done_q && edge_hit(mode[ttc_pkg::M_LOADA_LO +: 2], pin_a_in, a_prev_q);
  assign load_b = !gen && a_done_q && edge_hit(mode[ttc_pkg::M_LOADB_LO +: 2], pin_a_in, b_prev_q);

  // Previous levels for edge detection
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sel_prev_q <= 1'b0;
      a_prev_q <= 1'b0;
      b_prev_q <= 1'b0;
      ev_prev_q <= 1'b0;
      tr_prev_q <= 1'b0;
    end
    else
    begin
      sel_prev_q <= sel_clk;
      a_prev_q <= pin_a_in;
      b_prev_q <= pin_a_in;
      ev_prev_q <= ev_sig;
      tr_prev_q <= tr_sig;
    end
  end

  // Clock enable: off wins over on; disables on C match or value_b load also beat on
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      clk_enabled <= 1'b0;
    else if (clk_off)
      clk_enabled <= 1'b0;
    else if ((gen && c_hit && mode[ttc_pkg::M_DIS_C])
             || (load_b && mode[ttc_pkg::M_DIS_B]))
      clk_enabled <= 1'b0;
    else if (clk_on)
      clk_enabled <= 1'b1;
  end

  // Run state: a trigger starts, compare or load may stop
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      run_q <= 1'b0;
    else if (!clk_enabled)
      run_q <= clk_on && !clk_off;
    else if (trig)
      run_q <= 1'b1;
    else if ((gen && c_hit && mode[ttc_pkg::M_STOP_C])
             || (load_b && mode[ttc_pkg::M_STOP_B]))
      run_q <= 1'b0;
  end

  // Counter and direction
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cv_q <= 16'h0000;
      down_q <= 1'b0;
    end
    else if (trig && clk_enabled && c_hit && ud_restart && !soft_trig && !ext_trig)
    begin
      // Up-down restart turns at value_c instead of dropping to zero
      cv_q <= cv_q - 16'h0001;
      down_q <= 1'b1;
    end
    else if (trig && clk_enabled)
    begin
      cv_q <= 16'h0000;
      if (ud_restart)
        down_q <= !down_q;
      else
        down_q <= 1'b0;
    end
    else if (inc_en && run_q && clk_enabled)
    begin
      if (gen && mode[ttc_pkg::M_SHAPE_LO + ttc_pkg::SHAPE_UPDOWN])
      begin
        if (down_q)
        begin
          cv_q <= cv_q - 16'h0001;
          if (cv_q == 16'h0001)
            down_q <= 1'b0;
        end
        else
        begin
          cv_q <= cv_q + 16'h0001;
          if (cv_q == ttc_pkg::CNT_MAX - 16'h0001)
            down_q <= 1'b1;
        end
      end
      else
        cv_q <= cv_q + 16'h0001;
    end
  end

  // Capture and compare registers
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      va_q <= 16'h0000;
      vb_q <= 16'h0000;
      a_done_q <= 1'b0;
    end
    else
    begin
      if (load_a)
        va_q <= cv_q;
      else if (va_we)
        va_q <= va_wr;
      if (load_b)
        vb_q <= cv_q;
      else if (vb_we)
        vb_q <= vb_wr;
      if (trig || load_b)
        a_done_q <= 1'b0;
      else if (load_a)
        a_done_q <= 1'b1;
    end
  end

  // Output controller: software beats event beats C beats A/B compare
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
    end
    else if (gen)
    begin
      if (soft_trig)
        out_a_q <= act(mode[ttc_pkg::M_A_ON_SW_LO +: 2], out_a_q);
      else if (ev_hit)
        out_a_q <= act(mode[ttc_pkg::M_A_ON_EV_LO +: 2], out_a_q);
      else if (c_hit)
        out_a_q <= act(mode[ttc_pkg::M_A_ON_C_LO +: 2], out_a_q);
      else if ((cv_q == va_q) && inc_en && run_q)
        out_a_q <= act(mode[ttc_pkg::M_A_ON_A_LO +: 2], out_a_q);
      if (pin_b_in_use)
        out_b_q <= out_b_q;
      else if (soft_trig)
        out_b_q <= act(mode[ttc_pkg::M_B_ON_SW_LO +: 2], out_b_q);
      else if (ev_hit)
        out_b_q <= act(mode[ttc_pkg::M_B_ON_EV_LO +: 2], out_b_q);
      else if (c_hit)
        out_b_q <= act(mode[ttc_pkg::M_B_ON_C_LO +: 2], out_b_q);
      else if ((cv_q == vb_q) && inc_en && run_q)
        out_b_q <= act(mode[ttc_pkg::M_B_ON_B_LO +: 2], out_b_q);
    end
  end

  assign cv = cv_q;
  assign va = va_q;
  assign vb = vb_q;
  assign pin_a_out = out_a_q;
  assign pin_a_oe = gen;
  assign pin_b_out = out_b_q;
  assign pin_b_oe = gen && !pin_b_in_use;
endmodule

// >>> src/ttc_pkg.sv
// Package: register map, field positions and encodings of the three-channel timer
package ttc_pkg;
  localparam int unsigned NUM_CH = 3;
  localparam int unsigned CNT_W = 16;
  // Block address map (byte addresses)
  localparam logic [7:0] CH_STRIDE = 8'h40;
  localparam logic [7:0] BLOCK_CMD_OFS = 8'hC0;
  localparam logic [7:0] BLOCK_ROUTE_OFS = 8'hC4;
  // Channel-relative offsets
  localparam logic [5:0] CH_CMD_OFS = 6'h00;
  localparam logic [5:0] CH_MODE_OFS = 6'h04;
  localparam logic [5:0] CH_CV_OFS = 6'h10;
  localparam logic [5:0] CH_VA_OFS = 6'h14;
  localparam logic [5:0] CH_VB_OFS = 6'h18;
  localparam logic [5:0] CH_VC_OFS = 6'h1C;
  localparam logic [5:0] CH_STAT_OFS = 6'h20;
  localparam logic [5:0] CH_IEN_OFS = 6'h24;
  localparam logic [5:0] CH_IDIS_OFS = 6'h28;
  localparam logic [5:0] CH_IMASK_OFS = 6'h2C;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [5:0] ROUTE_RESET = 6'h00;
  // Command bits
  localparam int unsigned CMD_CLK_ON = 0;
  localparam int unsigned CMD_CLK_OFF = 1;
  localparam int unsigned CMD_SOFT = 2;
  localparam int unsigned BCMD_KICK = 0;
  // Mode fields common to both modes
  localparam int unsigned M_CLKPICK_LO = 0;
  localparam int unsigned M_INVERT = 3;
  localparam int unsigned M_GATE_LO = 4;
  localparam int unsigned M_GEN = 15;
  // Capture mode fields
  localparam int unsigned M_STOP_B = 6;
  localparam int unsigned M_DIS_B = 7;
  localparam int unsigned M_TRIGEDGE_LO = 8;
  localparam int unsigned M_TRIGPIN = 10;
  localparam int unsigned M_RETRIG_C = 14;
  localparam int unsigned M_LOADA_LO = 16;
  localparam int unsigned M_LOADB_LO = 18;
  // Generation mode fields
  localparam int unsigned M_STOP_C = 6;
  localparam int unsigned M_DIS_C = 7;
  localparam int unsigned M_EVEDGE_LO = 8;
  localparam int unsigned M_EVSEL_LO = 10;
  localparam int unsigned M_EVTRIG = 12;
  localparam int unsigned M_SHAPE_LO = 13;
  localparam int unsigned M_A_ON_A_LO = 16;
  localparam int unsigned M_A_ON_C_LO = 18;
  localparam int unsigned M_A_ON_EV_LO = 20;
  localparam int unsigned M_A_ON_SW_LO = 22;
  localparam int unsigned M_B_ON_B_LO = 24;
  localparam int unsigned M_B_ON_C_LO = 26;
  localparam int unsigned M_B_ON_EV_LO = 28;
  localparam int unsigned M_B_ON_SW_LO = 30;
  // Edge selection codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Output action codes
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_SET = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  // Event source: io_pin_b when zero
  localparam logic [1:0] EVSEL_PIN_B = 2'h0;
  // Count shape bits: bit1 restart on C, bit0 up-down
  localparam int unsigned SHAPE_UPDOWN = 0;
  localparam int unsigned SHAPE_RESTART = 1;
  // Clock routing codes
  localparam logic [1:0] ROUTE_PIN = 2'h0;
  localparam logic [1:0] ROUTE_NONE = 2'h1;
  // Internal clock dividers for clock_pick 0..4
  localparam int unsigned DIV_1 = 2;
  localparam int unsigned DIV_2 = 8;
  localparam int unsigned DIV_3 = 32;
  localparam int unsigned DIV_4 = 128;
  localparam int unsigned DIV_5 = 1024;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

// >>> src/ttc_prescaler.sv
// Internal clock-rate divider producing five one-cycle enable pulses
`timescale 1ns/100ps
module ttc_prescaler
#(
  parameter int unsigned MAX_DIV = ttc_pkg::DIV_5
)
(
  input wire logic mclk,
  input wire logic resetn,
  output logic [4:0] tick
);
  logic [9:0] div_q;

  // Elaboration-time guard: the tick taps below assume a 10-bit divider
  if (MAX_DIV != 1024)
  begin : g_bad_div
    $error("ttc_prescaler supports a 10-bit divider only");
  end

  // Free-running divider; pulse when low bits wrap
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      div_q <= 10'h000;
    else
      div_q <= div_q + 10'h001;
  end

  // Each tick is a one-cycle enable at its divided rate
  assign tick[0] = (div_q[0] == 1'b1);
  assign tick[1] = (div_q[2:0] == 3'h7);
  assign tick[2] = (div_q[4:0] == 5'h1F);
  assign tick[3] = (div_q[6:0] == 7'h7F);
  assign tick[4] = (div_q == 10'h3FF);
endmodule

// >>> src/ttc_top.sv
// Three-channel 16-bit timer/counter with Avalon-MM register slave
// Behaviour
// - Up-down with C restart: each trigger reverses counting direction.
// - C match stops clock if stop bit set, disables if disable bit set.
// - Generation event source is ext clock 0..2 or pin B, edge selectable.
// - Pin B as event source makes it input; B compare then does nothing.
// - External event triggers the counter only with event trigger enable.
// - Block kick and software trigger always trigger; C match when restart.
// - Pin A/B change on soft trigger, event, C match, own compare.
// - Channels at 0x00/0x40/0x80, block command 0xC0, routing 0xC4.
// - value_a and value_b writable only in generation mode.
// - Block command bit 0 kicks all channels at once.
// - Routing fields map pin clock, none, or other channels' pin A.
// - Clock-on command enables only without clock-off in same write.
// - Clock-off disables; soft trigger resets counter and starts clock only while the clock is enabled.
// - clock_pick picks internal clock one to five or ext clock 0..2.
// - clock_invert selects rising or falling edge counting of ext clocks.
// - gate_pick ANDs selected clock with an ext clock or none.
// - Capture: value_b load stops or disables clock per mode bits.
// - Capture trigger edge: none, rising, falling, or both.
// - Capture trigger pin: pin B when 0, pin A when 1.
// - Capture: C match retriggers only with retrigger bit.
// - Mode select bit chooses capture (0) or generation (1).
// - Load edge fields pick pin A edge loading value_a or value_b.
// - Event select 00 pin B as input, else ext clock 0..2.
// - Event edge codes: none, rising, falling, each.
// - Output actions: none, set, clear, toggle.
// - Count shape: up, up-down, each with or without C restart.
`timescale 1ns/100ps
module ttc_top
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [2:0] pin_clock,
  input wire logic [2:0] io_pin_a_in,
  output logic [2:0] io_pin_a_out,
  output logic [2:0] io_pin_a_oe,
  input wire logic [2:0] io_pin_b_in,
  output logic [2:0] io_pin_b_out,
  output logic [2:0] io_pin_b_oe
);
  logic [4:0] tick;
  logic [31:0] mode_q [3];
  logic [15:0] vc_q [3];
  logic [5:0] route_q;
  logic [2:0] xc;
  logic [15:0] cv [3];
  logic [15:0] va [3];
  logic [15:0] vb [3];
  logic [2:0] clk_en;
  logic [2:0] cmd_on;
  logic [2:0] cmd_off;
  logic [2:0] cmd_soft;
  logic [2:0] va_we;
  logic [2:0] vb_we;
  logic [2:0] ch_sel;
  logic [5:0] ch_ofs;
  logic wr_full;
  logic kick;
  logic rd_ack_q;
  logic [31:0] rd_q;

  // Whole-word writes only; partial byte writes to command words are ignored
  assign wr_full = avs_write && (avs_byteenable == 4'hF);
  assign ch_ofs = avs_address[5:0];
  assign kick = wr_full && (avs_address == ttc_pkg::BLOCK_CMD_OFS)
    && avs_writedata[ttc_pkg::BCMD_KICK];

  ttc_prescaler u_presc
  (
    .mclk(mclk),
    .resetn(resetn),
    .tick(tick)
  );

  // External clock routing
  always_comb
  begin
    for (int k = 0; k < 3; k++)
    begin
      unique case (route_q[2*k +: 2])
        ttc_pkg::ROUTE_PIN: xc[k] = pin_clock[k];
        ttc_pkg::ROUTE_NONE: xc[k] = 1'b0;
        2'h2: xc[k] = io_pin_a_out[(k == 0) ? 1 : 0];
        2'h3: xc[k] = io_pin_a_out[(k == 2) ? 1 : 2];
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_ch
      // Channel window decode at 0x00, 0x40, 0x80
      assign ch_sel[g] = (avs_address[7:6] == 2'(g));
      assign cmd_on[g] = wr_full && ch_sel[g] && (ch_ofs == ttc_pkg::CH_CMD_OFS)
        && avs_writedata[ttc_pkg::CMD_CLK_ON] && !avs_writedata[ttc_pkg::CMD_CLK_OFF];
      assign cmd_off[g] = wr_full && ch_sel[g] && (ch_ofs == ttc_pkg::CH_CMD_OFS)
        && avs_writedata[ttc_pkg::CMD_CLK_OFF];
      assign cmd_soft[g] = kick || (wr_full && ch_sel[g] && (ch_ofs == ttc_pkg::CH_CMD_OFS)
        && avs_writedata[ttc_pkg::CMD_SOFT]);
      assign va_we[g] = wr_full && ch_sel[g] && (ch_ofs == ttc_pkg::CH_VA_OFS)
        && mode_q[g][ttc_pkg::M_GEN];
      assign vb_we[g] = wr_full && ch_sel[g] && (ch_ofs == ttc_pkg::CH_VB_OFS)
        && mode_q[g][ttc_pkg::M_GEN];

      // Mode and compare-C registers
      always_ff @(posedge mclk or negedge resetn)
      begin
        if (!resetn)
        begin
          mode_q[g] <= ttc_pkg::MODE_RESET;
          vc_q[g] <= 16'h0000;
        end
        else if (wr_full && ch_sel[g])
        begin
          if (ch_ofs == ttc_pkg::CH_MODE_OFS)
            mode_q[g] <= avs_writedata;
          if (ch_ofs == ttc_pkg::CH_VC_OFS)
            vc_q[g] <= avs_writedata[15:0];
        end
      end

      ttc_channel u_ch
      (
        .mclk(mclk),
        .resetn(resetn),
        .mode(mode_q[g]),
        .va_wr(avs_writedata[15:0]),
        .va_we(va_we[g]),
        .vb_wr(avs_writedata[15:0]),
        .vb_we(vb_we[g]),
        .vc(vc_q[g]),
        .clk_on(cmd_on[g]),
        .clk_off(cmd_off[g]),
        .soft_trig(cmd_soft[g]),
        .tick(tick),
        .xc(xc),
        .pin_a_in(io_pin_a_in[g]),
        .pin_b_in(io_pin_b_in[g]),
        .cv(cv[g]),
        .va(va[g]),
        .vb(vb[g]),
        .clk_enabled(clk_en[g]),
        .pin_a_out(io_pin_a_out[g]),
        .pin_a_oe(io_pin_a_oe[g]),
        .pin_b_out(io_pin_b_out[g]),
        .pin_b_oe(io_pin_b_oe[g])
      );
    end
  endgenerate

  // Block routing register
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      route_q <= ttc_pkg::ROUTE_RESET;
    else if (wr_full && (avs_address == ttc_pkg::BLOCK_ROUTE_OFS))
      route_q <= avs_writedata[5:0];
  end

  // Read path: one wait cycle, data registered; unmapped reads give zero
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_ack_q <= 1'b0;
      rd_q <= ttc_pkg::RD_ZERO;
    end
    else
    begin
      rd_ack_q <= avs_read && !rd_ack_q;
      rd_q <= ttc_pkg::RD_ZERO;
      if (avs_address == ttc_pkg::BLOCK_ROUTE_OFS)
        rd_q <= {26'h000_0000, route_q};
      else if (avs_address[7:6] != 2'h3)
      begin
        unique case (ch_ofs)
          ttc_pkg::CH_MODE_OFS: rd_q <= mode_q[avs_address[7:6]];
          ttc_pkg::CH_CV_OFS: rd_q <= {16'h0000, cv[avs_address[7:6]]};
          ttc_pkg::CH_VA_OFS: rd_q <= {16'h0000, va[avs_address[7:6]]};
          ttc_pkg::CH_VB_OFS: rd_q <= {16'h0000, vb[avs_address[7:6]]};
          ttc_pkg::CH_VC_OFS: rd_q <= {16'h0000, vc_q[avs_address[7:6]]};
          ttc_pkg::CH_STAT_OFS: rd_q <= {31'h0000_0000, clk_en[avs_address[7:6]]};
          default: rd_q <= ttc_pkg::RD_ZERO;
        endcase
      end
    end
  end

  // Writes complete at once; reads wait one cycle for registered data
  assign avs_waitrequest = avs_read && !rd_ack_q;
  assign avs_readdata = rd_q;

  sync_trig_a: assert property (@(posedge mclk) disable iff (!resetn)
    kick |-> (cmd_soft == 3'h7)) else $error("block kick missed a channel");
  on_off_a: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_full && ch_sel[1] && ch_ofs == ttc_pkg::CH_CMD_OFS
     && avs_writedata[ttc_pkg::CMD_CLK_OFF])
    |=> !clk_en[1]) else $error("clock-off did not disable");
  on_only_a: assert property (@(posedge mclk) disable iff (!resetn)
    cmd_on[1] |=> clk_en[1]) else $error("clock-on did not enable");
  va_lock_a: assert property (@(posedge mclk) disable iff (!resetn)
    (!mode_q[2][ttc_pkg::M_GEN] && avs_write && ch_sel[2] && ch_ofs == ttc_pkg::CH_VA_OFS)
    |-> !va_we[2]) else $error("value_a writable in capture");
  pin_b_dir_a: assert property (@(posedge mclk) disable iff (!resetn)
    (mode_q[2][ttc_pkg::M_GEN] && mode_q[2][11:10] == 2'h0) |-> !io_pin_b_oe[2])
    else $error("pin B driven while event input");
  capt_dir_a: assert property (@(posedge mclk) disable iff (!resetn)
    !mode_q[0][ttc_pkg::M_GEN] |-> (io_pin_a_oe[0] == 1'b0)) else $error("pin A driven");
  read_wait_a: assert property (@(posedge mclk) disable iff (!resetn)
    (avs_read && !rd_ack_q) |=> (avs_read |-> !avs_waitrequest))
    else $error("read wait exceeded one cycle");
  cv_hi_a: assert property (@(posedge mclk) disable iff (!resetn)
    (rd_ack_q && avs_address[7:6] != 2'h3 && ch_ofs == ttc_pkg::CH_CV_OFS)
    |-> (avs_readdata[31:16] == 16'h0000))
    else $error("counter upper bits not zero");
  route_none_a: assert property (@(posedge mclk) disable iff (!resetn)
    (route_q[1:0] == ttc_pkg::ROUTE_NONE) |-> !xc[0]) else $error("routing none");
  kick_c: cover property (@(posedge mclk) disable iff (!resetn) kick);
  gen_c: cover property (@(posedge mclk) disable iff (!resetn) io_pin_a_out[0] && io_pin_a_oe[0]);
  cap_c: cover property (@(posedge mclk) disable iff (!resetn) va[0] != 16'h0000);
endmodule
